// >>> pkg/brl_defs.svh
/*
 * Constants for the boost regulator limit and status register bank:
 * register offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design file.
 */
// Overview of operation
// - ceiling register holds five-bit voltage code, 2.85 V to 4.4 V, reset 01110
// - limit register low four bits hold limit code, 1500 to 5000 mA, reset 1111
// - limit bit 5 set disables current limiting; resets to zero
// - limit bit 4 set caps soft-start valley current near 1250 mA; resets to one
// - status bit 7 latches a thermal trip until the status register is read
// - status bit 6 is live: one while junction is above 115 C
// - status bit 5 is live: zero in pulse-frequency, one in pulse-width mode
// - status bit 4 is live: zero in pass-through, one in dc/dc conversion
// - status bit 3 latches a bypass transistor overcurrent until status is read
// - status bit 2 latches after input current limit holds 1.5 ms while boosting
// - status bit 1 latches the power stage fault input until the status register is read; other trips leave it clear
// - status bit 0 shows output in range, and reads one when pass-through is forced
`ifndef BRL_DEFS_SVH
`define BRL_DEFS_SVH

`define BRL_OFS_CEILING 8'h03
`define BRL_OFS_LIMIT 8'h04
`define BRL_OFS_COND 8'h05

`define BRL_CEILING_RST 8'h0E
`define BRL_LIMIT_RST 8'h1F
`define BRL_COND_RST 8'h00

`define BRL_VCODE_MSB 4
`define BRL_ILIM_MSB 3
`define BRL_SOFTSTART_BIT 4
`define BRL_LIMDIS_BIT 5

`define BRL_COND_THERMAL 7
`define BRL_COND_WARM 6
`define BRL_COND_SCHEME 5
`define BRL_COND_PATH 4
`define BRL_COND_BYPASS_OC 3
`define BRL_COND_BOOST_OC 2
`define BRL_COND_FAULT 1
`define BRL_COND_OUTPUT_IN_RANGE 0

`define BRL_CLK_PERIOD_PS 8000
`define BRL_BOOST_OC_HOLD_NS 1500000
`define BRL_BOOST_OC_HOLD_CYC ((`BRL_BOOST_OC_HOLD_NS * 1000) / `BRL_CLK_PERIOD_PS)

// arbitrary neutral bus address
`define BRL_BUS_ADDR 7'h3A

`endif

// >>> pkg/brl_pkg.sv
/*
 * Types for the boost regulator limit and status register bank.
 * Assumes brl_defs.svh is on the include path.
 */
package brl_pkg;
   `include "brl_defs.svh"

   // conditions reported by the power stage
   typedef struct packed {
      logic thermal_trip;
      logic die_warm;
      logic pwm_active;
      logic dcdc_active;
      logic bypass_oc;
      logic boost_oc;
      logic fault;
      logic output_ok;
      logic forced_passthrough;
   } brl_cond_s;

   // settings driven to the power stage
   typedef struct packed {
      logic [4:0] target_voltage_code;
      logic [3:0] current_limit_code;
      logic limit_disable;
      logic softstart_cap;
   } brl_ctrl_s;

   typedef enum logic [3:0] {
      BRL_IDLE = 4'b0000,
      BRL_ADDR = 4'b0001,
      BRL_ADDR_ACK = 4'b0010,
      BRL_PTR = 4'b0011,
      BRL_PTR_ACK = 4'b0100,
      BRL_WDATA = 4'b0101,
      BRL_WACK = 4'b0110,
      BRL_RDATA = 4'b0111,
      BRL_RACK = 4'b1000
   } brl_state_e;
endpackage

// >>> logic/brl_regs.sv
/*
 * Register bank of the boost regulator: voltage ceiling, current limit
 * setup and regulator condition, reached over a two-wire serial bus slave.
 * Assumes scl and sda are already synchronous to clk and that sda is an
 * open-drain wire resolved outside from sda_oe.
 */
`include "brl_defs.svh"

module brl_regs #(
   parameter int unsigned BOOST_OC_HOLD_CYC = `BRL_BOOST_OC_HOLD_CYC,
   parameter logic [6:0] BUS_ADDR = `BRL_BUS_ADDR
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // serial bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // power stage conditions
   input brl_pkg::brl_cond_s cond_i,
   // power stage settings
   output brl_pkg::brl_ctrl_s ctrl_o
);
   import brl_pkg::*;

   brl_state_e st_q;

   // bus line history for edge and start/stop detection
   logic scl_prev_q;
   logic sda_prev_q;

   // byte shifter, bit count and register pointer
   logic [7:0] sh_q;
   logic [3:0] cnt_q;
   logic [7:0] ptr_q;
   logic rw_q;
   logic mack_q;

   // writable registers, reserved bits kept
   logic [7:0] ceiling_q;
   logic [7:0] limit_q;

   // status bits as reported
   logic thermal_q;
   logic warm_q;
   logic scheme_q;
   logic path_q;
   logic byp_oc_q;
   logic bst_oc_q;
   logic fault_q;
   logic output_in_range_q;

   // persistence counter for the boost input limit
   logic [31:0] hold_cnt_q;

   // decoded bus events and strobes
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic load_c;
   logic wr_c;
   logic [7:0] cond_c;
   logic [7:0] rd_val_c;

   function automatic logic [7:0] read_mux(input logic [7:0] ofs, input logic [7:0] ceil,
                                           input logic [7:0] lim, input logic [7:0] cnd);
      logic [7:0] v;
      v = 8'h00;
      if (ofs == `BRL_OFS_CEILING) begin
         v = ceil;
      end else if (ofs == `BRL_OFS_LIMIT) begin
         v = lim;
      end else if (ofs == `BRL_OFS_COND) begin
         v = cnd;
      end
      return v;
   endfunction

   assign scl_rise = scl_i & ~scl_prev_q;
   assign scl_fall = ~scl_i & scl_prev_q;
   assign start_c = scl_i & scl_prev_q & sda_prev_q & ~sda_i;
   assign stop_c = scl_i & scl_prev_q & ~sda_prev_q & sda_i;

   // read byte loaded on the falling edge that starts a data byte
   assign load_c = scl_fall & rw_q & ((st_q == BRL_ADDR_ACK) | ((st_q == BRL_RACK) & mack_q));
   assign wr_c = scl_fall & (st_q == BRL_WDATA) & (cnt_q == 4'd8);

   assign cond_c = {thermal_q, warm_q, scheme_q, path_q, byp_oc_q, bst_oc_q, fault_q, output_in_range_q};
   assign rd_val_c = read_mux(ptr_q, ceiling_q, limit_q, cond_c);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_i;
         sda_prev_q <= sda_i;
      end
   end


   // serial slave sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= BRL_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         sda_oe <= 1'b0;
      end else if (start_c) begin
         st_q <= BRL_ADDR;
         cnt_q <= 4'h0;
         rw_q <= 1'b0;
         sda_oe <= 1'b0;
      end else if (stop_c) begin
         st_q <= BRL_IDLE;
         sda_oe <= 1'b0;
      end else if (scl_rise) begin
         case (st_q)
            BRL_ADDR, BRL_PTR, BRL_WDATA: begin
               sh_q <= {sh_q[6:0], sda_i};
               cnt_q <= cnt_q + 4'd1;
            end
            BRL_RDATA: begin
               cnt_q <= cnt_q + 4'd1;
            end
            BRL_RACK: begin
               mack_q <= ~sda_i;
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (st_q)
            BRL_ADDR: begin
               if (cnt_q == 4'd8) begin
                  if (sh_q[7:1] == BUS_ADDR) begin
                     st_q <= BRL_ADDR_ACK;
                     rw_q <= sh_q[0];
                     sda_oe <= 1'b1;
                  end else begin
                     st_q <= BRL_IDLE;
                  end
               end
            end
            BRL_ADDR_ACK: begin
               cnt_q <= 4'h0;
               if (rw_q) begin
                  st_q <= BRL_RDATA;
                  sh_q <= rd_val_c;
                  sda_oe <= ~rd_val_c[7];
                  ptr_q <= ptr_q + 8'd1;
               end else begin
                  st_q <= BRL_PTR;
                  sda_oe <= 1'b0;
               end
            end
            BRL_PTR: begin
               if (cnt_q == 4'd8) begin
                  ptr_q <= sh_q;
                  st_q <= BRL_PTR_ACK;
                  sda_oe <= 1'b1;
               end
            end
            BRL_PTR_ACK, BRL_WACK: begin
               st_q <= BRL_WDATA;
               cnt_q <= 4'h0;
               sda_oe <= 1'b0;
            end
            BRL_WDATA: begin
               if (cnt_q == 4'd8) begin
                  ptr_q <= ptr_q + 8'd1;
                  st_q <= BRL_WACK;
                  sda_oe <= 1'b1;
               end
            end
            BRL_RDATA: begin
               if (cnt_q == 4'd8) begin
                  st_q <= BRL_RACK;
                  sda_oe <= 1'b0;
               end else begin
                  sh_q <= {sh_q[6:0], 1'b0};
                  sda_oe <= ~sh_q[6];
               end
            end
            BRL_RACK: begin
               cnt_q <= 4'h0;
               if (mack_q) begin
                  st_q <= BRL_RDATA;
                  sh_q <= rd_val_c;
                  sda_oe <= ~rd_val_c[7];
                  ptr_q <= ptr_q + 8'd1;
               end else begin
                  // controller declined more data; wait for stop or restart
                  st_q <= BRL_IDLE;
               end
            end
            default: begin
            end
         endcase
      end
   end


   // line only ever pulled low
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end


   // writable registers; condition offset is not writable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ceiling_q <= `BRL_CEILING_RST;
         limit_q <= `BRL_LIMIT_RST;
      end else if (wr_c) begin
         if (ptr_q == `BRL_OFS_CEILING) begin
            ceiling_q <= sh_q;
         end else if (ptr_q == `BRL_OFS_LIMIT) begin
            limit_q <= sh_q;
         end
      end
   end


   // settings to the power stage; reserved bits are not forwarded
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_o <= '0;
      end else begin
         ctrl_o.target_voltage_code <= ceiling_q[`BRL_VCODE_MSB:0];
         ctrl_o.current_limit_code <= limit_q[`BRL_ILIM_MSB:0];
         ctrl_o.limit_disable <= limit_q[`BRL_LIMDIS_BIT];
         ctrl_o.softstart_cap <= limit_q[`BRL_SOFTSTART_BIT];
      end
   end


   // input limit must persist while boosting before it is reported
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_cnt_q <= 32'd0;
      end else if (!(cond_i.boost_oc && cond_i.dcdc_active)) begin
         hold_cnt_q <= 32'd0;
      end else if (hold_cnt_q < BOOST_OC_HOLD_CYC) begin
         hold_cnt_q <= hold_cnt_q + 32'd1;
      end
   end


   // live status bits
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         warm_q <= 1'b0;
         scheme_q <= 1'b0;
         path_q <= 1'b0;
         output_in_range_q <= 1'b0;
      end else begin
         warm_q <= cond_i.die_warm;
         scheme_q <= cond_i.pwm_active;
         path_q <= cond_i.dcdc_active;
         output_in_range_q <= cond_i.output_ok | cond_i.forced_passthrough;
      end
   end


   // sticky flags; a new event wins over the read that clears
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         thermal_q <= 1'b0;
         byp_oc_q <= 1'b0;
         bst_oc_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         if (cond_i.thermal_trip) begin
            thermal_q <= 1'b1;
         end else if (load_c && ptr_q == `BRL_OFS_COND) begin
            thermal_q <= 1'b0;
         end
         if (cond_i.bypass_oc) begin
            byp_oc_q <= 1'b1;
         end else if (load_c && ptr_q == `BRL_OFS_COND) begin
            byp_oc_q <= 1'b0;
         end
         if (hold_cnt_q >= BOOST_OC_HOLD_CYC) begin
            bst_oc_q <= 1'b1;
         end else if (load_c && ptr_q == `BRL_OFS_COND) begin
            bst_oc_q <= 1'b0;
         end
         if (cond_i.fault) begin
            fault_q <= 1'b1;
         end else if (load_c && ptr_q == `BRL_OFS_COND) begin
            fault_q <= 1'b0;
         end
      end
   end
endmodule

// >>> tb/brl_regs_asserts.sv
/* checker on the brl_regs ports, bound to every instance.
   assumes brl_pkg is compiled first; one clock domain. */
module brl_regs_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // bus and settings
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input brl_pkg::brl_ctrl_s ctrl_o
);
   timeunit 1ns / 100ps;
   import brl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_rel;
      $rose(rst_b);
   endsequence
   sequence s_scl_high;
      scl_i ##1 scl_i;
   endsequence
   AST_VCODE_RST: assert property (s_rel |=> ctrl_o.target_voltage_code == 5'h0e)
      else $error("voltage code reset wrong");
   AST_ILIM_RST: assert property (s_rel |=> ctrl_o.current_limit_code == 4'hf)
      else $error("limit code reset wrong");
   AST_LIMDIS_RST: assert property (s_rel |=> !ctrl_o.limit_disable)
      else $error("limit disable reset wrong");
   AST_SSCAP_RST: assert property (s_rel |=> ctrl_o.softstart_cap)
      else $error("soft-start cap reset wrong");
   // past the move out of reset, settings only move after a byte ends, so never with scl high
   AST_CTRL_CALM: assert property (s_scl_high ##0 $past(rst_b, 2) |-> $stable(ctrl_o))
      else $error("settings moved with scl high");
   AST_OE_CALM: assert property (s_scl_high |-> $stable(sda_oe))
      else $error("drive moved with scl high");
   AST_OE_AFTER_FALL: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i))
      else $error("drive moved outside scl low");
   AST_OE_LOW: assert property (sda_oe |-> sda_o == 1'h0)
      else $error("drive not low");
endmodule
bind brl_regs brl_regs_asserts chk (.clk(clk), .rst_b(rst_b), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe(sda_oe), .ctrl_o(ctrl_o));

// >>> tb/brl_host.sv
/* serial bus controller model, one transfer at a time.
   assumes the bench resolves the data wire with a pull-up. */
module brl_host #(
   parameter logic [6:0] BUS_ADDR = 7'h3a
) (
   // clock
   input wire logic clk,
   // bus
   output logic scl,
   output logic sda_dn,
   input wire logic sda
);
   timeunit 1ns / 100ps;
   initial begin
      scl = 1'h1;
      sda_dn = 1'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // data moves only while scl is low
   task automatic bit_io(input logic b, output logic r);
      sda_dn <= !b;
      tick(4);
      scl <= 1'h1;
      tick(4);
      r = sda;
      scl <= 1'h0;
      tick(3);
   endtask
   // start, repeated start or stop: sda moves while scl is high
   task automatic frame(input logic stp);
      sda_dn <= stp;
      tick(4);
      scl <= 1'h1;
      tick(4);
      sda_dn <= !stp;
      tick(4);
      if (!stp) begin
         scl <= 1'h0;
         tick(3);
      end
   endtask
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      // ninth bit released: device ack, or our closing nack
      bit_io(1'h1, r);
   endtask
   task automatic xfer(input logic rd, input logic [7:0] p, input logic [7:0] w,
      output logic [7:0] r);
      logic [7:0] w2;
      w2 = w;
      frame(1'h0);
      byte_io({BUS_ADDR, 1'h0}, r);
      byte_io(p, r);
      if (rd) begin
         frame(1'h0);
         byte_io({BUS_ADDR, 1'h1}, r);
         w2 = 8'hff;
      end
      byte_io(w2, r);
      frame(1'h1);
   endtask
endmodule

// >>> tb/test_brl_regs.sv
/* self-checking bench for brl_regs through the bus controller model.
   assumes brl_pkg, the design, the model and the checker are compiled. */
module test_brl_regs;
   timeunit 1ns / 100ps;
   import brl_pkg::*;
   // short boost hold keeps the run brief
   localparam int HOLD = 20;
   logic clk;
   logic rst_b;
   logic scl;
   logic sda_dn;
   logic sda_o;
   logic sda_oe;
   brl_cond_s cond;
   brl_ctrl_s ctrl;
   wire sda = !(sda_dn || (sda_oe && !sda_o));
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [7:0] d;
   brl_regs #(.BOOST_OC_HOLD_CYC(HOLD)) uut (.clk(clk), .rst_b(rst_b), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .cond_i(cond), .ctrl_o(ctrl));
   brl_host host (.clk(clk), .scl(scl), .sda_dn(sda_dn), .sda(sda));
   initial begin
      clk = 1'h0;
      forever #4 clk = !clk;
   end
   task automatic stop_test();
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask
   task automatic rchk(input logic [7:0] p, input logic [7:0] e);
      host.xfer(1'h1, p, 8'h00, d);
      chk("register read", {3'h0, e}, {3'h0, d});
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] w);
      host.xfer(1'h0, p, w, d);
   endtask
   task automatic drive(input logic [8:0] v, input int n);
      @(posedge clk);
      cond <= v;
      repeat (n) @(posedge clk);
   endtask
   task automatic t_reset();
      chk("ctrl", {5'h0e, 4'hf, 1'h0, 1'h1}, ctrl);
      rchk(8'h03, 8'h0e);
      rchk(8'h04, 8'h1f);
      rchk(8'h05, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_write();
      wr(8'h03, 8'hff);
      wr(8'h04, 8'he8);
      wr(8'h05, 8'hff);
      chk("ctrl", {5'h1f, 4'h8, 1'h1, 1'h0}, ctrl);
      rchk(8'h03, 8'hff);
      rchk(8'h04, 8'he8);
      rchk(8'h05, 8'h00);
      rchk(8'h00, 8'h00);
      $display("t_write done");
   endtask
   task automatic t_live();
      drive(9'h0e2, 0);
      rchk(8'h05, 8'h71);
      drive(9'h0c1, 0);
      rchk(8'h05, 8'h61);
      $display("t_live done");
   endtask
   task automatic t_sticky();
      drive(9'h114, 0);
      drive(9'h000, 0);
      rchk(8'h05, 8'h8a);
      rchk(8'h05, 8'h00);
      drive(9'h100, 0);
      rchk(8'h05, 8'h80);
      rchk(8'h05, 8'h80);
      drive(9'h000, 0);
      rchk(8'h05, 8'h80);
      rchk(8'h05, 8'h00);
      $display("t_sticky done");
   endtask
   task automatic t_boost();
      drive(9'h028, HOLD - 4);
      drive(9'h020, 0);
      rchk(8'h05, 8'h10);
      drive(9'h028, HOLD + 4);
      drive(9'h020, 0);
      rchk(8'h05, 8'h14);
      rchk(8'h05, 8'h10);
      $display("t_boost done");
   endtask
   initial begin
      rst_b = 1'h0;
      cond = 9'h000;
      repeat (4) @(posedge clk);
      rst_b <= 1'h1;
      repeat (3) @(posedge clk);
      t_reset();
      t_write();
      t_live();
      t_sticky();
      t_boost();
      stop_test();
   end
endmodule
